// ===== rtl/sofs_pkg.sv
// Summary of operation
// RL1: active mode exits safe state only when healthy
// RL2: soft watchdog reset asserts output if selected
// RL3: soft faults assert output before any shutdown
// RL4: fuse low selects fault safe state mode
// RL5: selected soft faults latch output and flag
// RL6: selected watchdog input event latches its flag
// RL7: selected watchdog counter reset latches its flag
// RL8: selected hard fault shutdown latches its flag
// RL9: five events count as hard fault shutdown
// RL10: release when flags clear or supply undervolt
// RL11: strap high selects mirror programming mode
// RL12: strap high forces slave address 0x08
// RL13: strap high disables all watchdog operation
// RL14: strap high, no power-on: disable CRC, secure
// RL15: fail-sync fuse low ignores the pin
// RL16: internal shutdown drives pin low 20 us early
// RL17: fail-sync pin held low in off modes
// RL18: 20 us peer low means fail, power down
// RL19: release pin at power-on, pause while held low
// RL20: hard watchdog: release 30 us after off, reload
// RL21: fuse code 0..7 maps to address 0x08..0x0F
// RL22: latch only whole bytes, partial byte no ack
package sofs_pkg;
  // clock rate and derived period
  localparam int MCLK_HZ = 20000000;
  localparam int MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;
  // fail-sync timing, in nanoseconds
  localparam int FS_PRE_DOWN_NS = 20000;
  localparam int FS_DEBOUNCE_NS = 20000;
  localparam int FS_HARD_REL_NS = 30000;
  // least times, rounded up to whole cycles
  localparam int FS_PRE_DOWN_CYC = (FS_PRE_DOWN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int FS_DEBOUNCE_CYC = (FS_DEBOUNCE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int FS_HARD_REL_CYC = (FS_HARD_REL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int FS_CNT_W = 10;
  localparam logic [FS_CNT_W-1:0] FS_PRE_DOWN_LAST = FS_CNT_W'(FS_PRE_DOWN_CYC - 1);
  localparam logic [FS_CNT_W-1:0] FS_DEBOUNCE_LAST = FS_CNT_W'(FS_DEBOUNCE_CYC - 1);
  localparam logic [FS_CNT_W-1:0] FS_HARD_REL_LAST = FS_CNT_W'(FS_HARD_REL_CYC - 1);
  localparam logic [FS_CNT_W-1:0] FS_CNT_ZERO = 10'h000;
  localparam logic [FS_CNT_W-1:0] FS_CNT_ONE = 10'h001;
  // i2c address selection
  localparam logic [6:0] I2C_BASE_ADDR = 7'h08;
  localparam logic [6:0] I2C_STRAP_ADDR = 7'h08;
  localparam logic [3:0] I2C_LAST_BIT = 4'h7;
  localparam logic [3:0] I2C_CNT_ZERO = 4'h0;
  localparam logic [3:0] I2C_CNT_ONE = 4'h1;
  // active safe flag comes up set once fuses are loaded
  localparam logic ASS_RESET_VAL = 1'b1;
  // synchroniser lanes
  localparam int PIN_STRAP = 0;
  localparam int PIN_FSYNC = 1;
  localparam int PIN_SCL = 2;
  localparam int PIN_SDA = 3;
  localparam int PIN_NUM = 4;

  typedef enum logic [2:0] {
    FS_OFF = 3'b000,
    FS_WAIT_REL = 3'b001,
    FS_ON = 3'b010,
    FS_PRE_DOWN = 3'b011,
    FS_DOWN = 3'b100,
    FS_HARD_HOLD = 3'b101
  } sofs_fsync_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_DATA = 2'b10,
    RX_SKIP = 2'b11
  } sofs_rx_e;

  // hard fault shutdown causes
  typedef struct packed {
    logic fault_timer;
    logic regulator_fault_limit;
    logic wdog_event_limit;
    logic pwrup_fail;
    logic thermal_sd;
  } sofs_hard_s;

  // safety flags, also used for write-one-to-clear pulses
  typedef struct packed {
    logic active_safe;
    logic soft_fault_safe_flag;
    logic wdog_input_safe_flag;
    logic wdog_counter_safe_flag;
    logic hard_fault_safe_flag;
  } sofs_flags_s;

  // fault selection bits
  typedef struct packed {
    logic safe_sel_wdog_input;
    logic safe_sel_wdog_counter;
    logic safe_sel_soft_fault;
    logic safe_sel_hard_fault;
  } sofs_sel_s;
endpackage

// ===== rtl/sofs_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one lane per bit
module sofs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage, read by second stage only

  generate
    if (W < 1) begin : g_chk
      $error("sofs_sync width must be at least one");
    end
  endgenerate

  // both stages reset to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ===== rtl/sofs_i2c_rx.sv
`timescale 1ns/1ps
// write-only i2c slave byte receiver on oversampled scl and sda
module sofs_i2c_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] addr_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic sda_oe_n_o
);
  sofs_pkg::sofs_rx_e state_q; // transfer phase
  logic scl_q; // previous scl sample
  logic sda_q; // previous sda sample
  logic [3:0] cnt_q; // bits taken in this byte
  logic [7:0] shift_q; // incoming bits, msb first
  logic ack_pend_q; // ack owed at next scl fall
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic [7:0] word_c;

  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign rise_c = scl_i & ~scl_q;
  assign fall_c = ~scl_i & scl_q;
  assign word_c = {shift_q[6:0], sda_i};

  // edge history of the bus lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // bit shifting and byte decisions
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sofs_pkg::RX_IDLE;
      cnt_q <= sofs_pkg::I2C_CNT_ZERO;
      shift_q <= 8'h00;
      ack_pend_q <= 1'b0;
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
    end else begin
      byte_valid_o <= 1'b0;
      if (start_c) begin
        // a start drops any partial byte unseen
        state_q <= sofs_pkg::RX_ADDR; // RL22
        cnt_q <= sofs_pkg::I2C_CNT_ZERO;
      end else if (stop_c) begin
        state_q <= sofs_pkg::RX_IDLE; // RL22
        cnt_q <= sofs_pkg::I2C_CNT_ZERO;
      end else if (rise_c && sda_oe_n_o && state_q != sofs_pkg::RX_IDLE) begin
        shift_q <= word_c;
        cnt_q <= cnt_q + sofs_pkg::I2C_CNT_ONE;
        if (cnt_q == sofs_pkg::I2C_LAST_BIT) begin
          // only a complete eighth bit commits anything
          cnt_q <= sofs_pkg::I2C_CNT_ZERO; // RL22
          case (state_q)
            sofs_pkg::RX_ADDR: begin
              // reads are not served, so only write addressing matches
              if (word_c[7:1] == addr_i && !word_c[0]) begin
                state_q <= sofs_pkg::RX_DATA;
                ack_pend_q <= 1'b1;
              end else begin
                state_q <= sofs_pkg::RX_SKIP;
              end
            end
            sofs_pkg::RX_DATA: begin
              byte_o <= word_c; // RL22
              byte_valid_o <= 1'b1;
              ack_pend_q <= 1'b1;
            end
            default: begin
              state_q <= sofs_pkg::RX_SKIP;
            end
          endcase
        end
      end else if (fall_c && ack_pend_q) begin
        ack_pend_q <= 1'b0;
      end
    end
  end

  // ack drive from the fall after bit 8 to the fall after bit 9
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_n_o <= 1'b1;
    end else if (start_c || stop_c) begin
      sda_oe_n_o <= 1'b1;
    end else if (fall_c) begin
      sda_oe_n_o <= ~ack_pend_q;
    end
  end
endmodule

// ===== rtl/sofs_top.sv
`timescale 1ns/1ps
// safety output, fail-sync pin, strap and i2c address control
module sofs_top #(
  parameter int NUM_REG = 7,
  parameter int NUM_SELF_TEST = 14
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic ACTIVE_SAFE_MODE_FUSE_I,
  input wire logic FAIL_SYNC_ENABLE_FUSE_I,
  input wire logic [2:0] I2C_ADDR_FUSE_I,
  input wire sofs_pkg::sofs_sel_s SAFE_SEL_I,
  input wire logic MCU_RESET_OUT_N_I,
  input wire logic [NUM_SELF_TEST-1:0] ANALOG_SELF_TEST_I,
  input wire logic [NUM_REG-1:0] OVERVOLT_FAULT_I,
  input wire logic [NUM_REG-1:0] UNDERVOLT_FAULT_I,
  input wire logic [NUM_REG-1:0] CURRENT_LIMIT_FAULT_I,
  input wire sofs_pkg::sofs_hard_s HARD_FAULT_I,
  input wire logic WDOG_INPUT_EVENT_I,
  input wire logic SOFT_WDOG_RESET_I,
  input wire logic WDOG_COUNTER_RESET_I,
  input wire logic HARD_WDOG_EVENT_I,
  input wire logic SUPPLY_UNDERVOLT_DETECT_I,
  input wire sofs_pkg::sofs_flags_s FLAG_CLEAR_I,
  input wire logic POWER_ON_REQUEST_I,
  input wire logic POWERDOWN_DONE_I,
  input wire logic CONFIG_MODE_STRAP_I,
  input wire logic FAIL_SYNC_PIN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SAFETY_OUTPUT_O,
  output logic SAFETY_OUTPUT_OE_N_O,
  output sofs_pkg::sofs_flags_s SAFE_FLAGS_O,
  output logic FAIL_SYNC_PIN_O,
  output logic FAIL_SYNC_PIN_OE_N_O,
  output logic POWERUP_ENABLE_O,
  output logic POWERDOWN_START_O,
  output logic FUSE_RELOAD_O,
  output logic MIRROR_PROGRAMMING_MODE_O,
  output logic WDOG_DISABLE_O,
  output logic CRC_SECURE_DISABLE_O,
  output logic [6:0] I2C_ADDR_O,
  output logic I2C_BYTE_VALID_O,
  output logic [7:0] I2C_BYTE_O,
  output logic SDA_O,
  output logic SDA_OE_N_O
);
  logic [sofs_pkg::PIN_NUM-1:0] pins_s; // synchronised pin levels
  logic strap_s; // configuration strap, synchronised
  logic fsync_pin_s; // fail-sync pin level, synchronised
  logic pin_low_c; // peer or self holds the line low
  logic soft_fault_c; // any ov, uv or current limit
  logic hard_fault_c; // any hard fault shutdown cause
  logic wdog_input_c; // watchdog input event or soft watchdog reset, strap gated
  logic wdog_counter_c; // watchdog counter reset, strap gated
  logic hard_wdog_c; // hard watchdog event, strap gated
  logic ass_set_c; // a cause forcing the safe state
  logic ass_ok_c; // conditions allowing safe state exit
  logic safe_assert_c; // safety output wants to be low
  logic drive_low_c; // fail-sync state wants the pin low
  logic [6:0] addr_c; // slave address in use
  sofs_pkg::sofs_flags_s flags_q; // sticky safety flags
  sofs_pkg::sofs_flags_s flags_d;
  sofs_pkg::sofs_fsync_e state_q; // fail-sync sequencing state
  sofs_pkg::sofs_fsync_e state_d;
  logic [sofs_pkg::FS_CNT_W-1:0] cnt_q; // debounce and delay counter
  logic [sofs_pkg::FS_CNT_W-1:0] cnt_d;
  logic hard_path_q; // current shutdown came from a hard watchdog
  logic hard_path_d;
  logic pd_start_d;
  logic reload_d;
  logic rx_valid; // byte strobe from receiver
  logic [7:0] rx_byte;
  logic rx_oe_n;

  // parameter sanity
  generate
    if (NUM_REG < 1 || NUM_SELF_TEST < 1) begin : g_chk
      $error("sofs_top needs at least one regulator and one self-test flag");
    end
  endgenerate

  // all pins from outside pass two flops first
  sofs_sync #(
    .W(sofs_pkg::PIN_NUM)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .d_i({SDA_I, SCL_I, FAIL_SYNC_PIN_I, CONFIG_MODE_STRAP_I}),
    .q_o(pins_s)
  );

  assign strap_s = pins_s[sofs_pkg::PIN_STRAP];
  assign fsync_pin_s = pins_s[sofs_pkg::PIN_FSYNC];

  // with the fuse off the pin reads as released whatever it does
  assign pin_low_c = FAIL_SYNC_ENABLE_FUSE_I & ~fsync_pin_s; // RL15

  // fault event decode
  assign soft_fault_c = |{OVERVOLT_FAULT_I, UNDERVOLT_FAULT_I, CURRENT_LIMIT_FAULT_I};
  assign hard_fault_c = |HARD_FAULT_I; // RL9
  // watchdog sources are dead while in programming mode
  assign wdog_input_c = (WDOG_INPUT_EVENT_I | SOFT_WDOG_RESET_I) & ~strap_s; // RL13
  assign wdog_counter_c = WDOG_COUNTER_RESET_I & ~strap_s; // RL13
  assign hard_wdog_c = HARD_WDOG_EVENT_I & ~strap_s; // RL13

  // causes that push the active mode into its safe state
  assign ass_set_c = (|ANALOG_SELF_TEST_I)
                   | (flags_q.wdog_input_safe_flag & SAFE_SEL_I.safe_sel_wdog_input)
                   | (flags_q.soft_fault_safe_flag & SAFE_SEL_I.safe_sel_soft_fault)
                   | hard_wdog_c
                   | (state_q == sofs_pkg::FS_OFF && !MCU_RESET_OUT_N_I);

  // exit needs mcu out of reset, clean self test, no soft fault, no selected soft or watchdog input flag
  assign ass_ok_c = MCU_RESET_OUT_N_I
                  & ~(|ANALOG_SELF_TEST_I)
                  & ~soft_fault_c
                  & ~(flags_q.wdog_input_safe_flag & SAFE_SEL_I.safe_sel_wdog_input)
                  & ~(flags_q.soft_fault_safe_flag & SAFE_SEL_I.safe_sel_soft_fault); // RL1

  // next flag values; a set in the clearing cycle wins
  always_comb begin
    flags_d = flags_q;
    if (SUPPLY_UNDERVOLT_DETECT_I) begin
      // input supply collapsing: everything lets go
      flags_d = '0; // RL10
    end else begin
      // active safe state flag only lives in active mode
      if (!ACTIVE_SAFE_MODE_FUSE_I) begin
        flags_d.active_safe = 1'b0; // RL4
      end else if (ass_set_c) begin
        flags_d.active_safe = 1'b1;
      end else if (FLAG_CLEAR_I.active_safe && ass_ok_c) begin
        flags_d.active_safe = 1'b0; // RL1
      end
      // soft faults latch, even once the fault goes away
      if (SAFE_SEL_I.safe_sel_soft_fault && soft_fault_c) begin
        flags_d.soft_fault_safe_flag = 1'b1; // RL3 RL5
      end else if (FLAG_CLEAR_I.soft_fault_safe_flag) begin
        flags_d.soft_fault_safe_flag = 1'b0;
      end
      // watchdog input and soft watchdog reset share this flag
      if (SAFE_SEL_I.safe_sel_wdog_input && wdog_input_c) begin
        flags_d.wdog_input_safe_flag = 1'b1; // RL2 RL6
      end else if (FLAG_CLEAR_I.wdog_input_safe_flag) begin
        flags_d.wdog_input_safe_flag = 1'b0;
      end
      // internal watchdog counter resets
      if (SAFE_SEL_I.safe_sel_wdog_counter && wdog_counter_c) begin
        flags_d.wdog_counter_safe_flag = 1'b1; // RL7
      end else if (FLAG_CLEAR_I.wdog_counter_safe_flag) begin
        flags_d.wdog_counter_safe_flag = 1'b0;
      end
      // any of the five hard shutdown causes
      if (SAFE_SEL_I.safe_sel_hard_fault && hard_fault_c) begin
        flags_d.hard_fault_safe_flag = 1'b1; // RL8
      end else if (FLAG_CLEAR_I.hard_fault_safe_flag) begin
        flags_d.hard_fault_safe_flag = 1'b0;
      end
    end
  end

  // output low while any flag stands, released otherwise
  assign safe_assert_c = |flags_d; // RL10

  // flag storage; active flag starts set, dropped next cycle in fault mode
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_q <= '0;
      flags_q.active_safe <= sofs_pkg::ASS_RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  // safety pin drive, open drain: data low, enable when asserting
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SAFETY_OUTPUT_O <= 1'b0;
      SAFETY_OUTPUT_OE_N_O <= 1'b1;
      SAFE_FLAGS_O <= '0;
    end else begin
      SAFETY_OUTPUT_O <= 1'b0;
      SAFETY_OUTPUT_OE_N_O <= ~safe_assert_c; // RL4
      SAFE_FLAGS_O <= flags_d;
    end
  end

  // fail-sync sequencing
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hard_path_d = hard_path_q;
    pd_start_d = 1'b0;
    reload_d = 1'b0;
    case (state_q)
      sofs_pkg::FS_OFF: begin
        cnt_d = sofs_pkg::FS_CNT_ZERO;
        if (POWER_ON_REQUEST_I) begin
          state_d = sofs_pkg::FS_WAIT_REL; // RL19
        end
      end
      sofs_pkg::FS_WAIT_REL: begin
        // pin released by us; a peer still low keeps power-up paused
        if (!pin_low_c) begin
          state_d = sofs_pkg::FS_ON; // RL19
        end
      end
      sofs_pkg::FS_ON: begin
        if (hard_fault_c || hard_wdog_c) begin
          // own shutdown warns peers before sequencing down
          state_d = sofs_pkg::FS_PRE_DOWN; // RL16
          cnt_d = sofs_pkg::FS_CNT_ZERO;
          hard_path_d = hard_wdog_c;
        end else if (pin_low_c) begin
          // peer must stay low the whole debounce window
          if (cnt_q == sofs_pkg::FS_DEBOUNCE_LAST) begin
            state_d = sofs_pkg::FS_DOWN; // RL18
            pd_start_d = 1'b1;
            hard_path_d = 1'b0;
          end else begin
            cnt_d = cnt_q + sofs_pkg::FS_CNT_ONE;
          end
        end else begin
          cnt_d = sofs_pkg::FS_CNT_ZERO; // RL18
        end
      end
      sofs_pkg::FS_PRE_DOWN: begin
        if (cnt_q == sofs_pkg::FS_PRE_DOWN_LAST) begin
          state_d = sofs_pkg::FS_DOWN; // RL16
          pd_start_d = 1'b1;
          cnt_d = sofs_pkg::FS_CNT_ZERO;
        end else begin
          cnt_d = cnt_q + sofs_pkg::FS_CNT_ONE;
        end
      end
      sofs_pkg::FS_DOWN: begin
        if (POWERDOWN_DONE_I) begin
          cnt_d = sofs_pkg::FS_CNT_ZERO;
          state_d = hard_path_q ? sofs_pkg::FS_HARD_HOLD : sofs_pkg::FS_OFF; // RL20
        end
      end
      sofs_pkg::FS_HARD_HOLD: begin
        // outputs off; hold low, then let go and reload fuses
        if (cnt_q == sofs_pkg::FS_HARD_REL_LAST) begin
          state_d = sofs_pkg::FS_WAIT_REL; // RL20
          reload_d = 1'b1;
          hard_path_d = 1'b0;
        end else begin
          cnt_d = cnt_q + sofs_pkg::FS_CNT_ONE;
        end
      end
      default: begin
        state_d = sofs_pkg::FS_OFF;
        cnt_d = sofs_pkg::FS_CNT_ZERO;
      end
    endcase
  end

  // pin low in off, warning, power-down and hold phases
  assign drive_low_c = (state_d == sofs_pkg::FS_OFF)
                     | (state_d == sofs_pkg::FS_PRE_DOWN)
                     | (state_d == sofs_pkg::FS_DOWN)
                     | (state_d == sofs_pkg::FS_HARD_HOLD); // RL17

  // sequencing state storage
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= sofs_pkg::FS_OFF;
      cnt_q <= sofs_pkg::FS_CNT_ZERO;
      hard_path_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hard_path_q <= hard_path_d;
    end
  end

  // fail-sync pin and sequencer handshake outputs
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      FAIL_SYNC_PIN_O <= 1'b0;
      FAIL_SYNC_PIN_OE_N_O <= 1'b1;
      POWERUP_ENABLE_O <= 1'b0;
      POWERDOWN_START_O <= 1'b0;
      FUSE_RELOAD_O <= 1'b0;
    end else begin
      FAIL_SYNC_PIN_O <= 1'b0;
      // fuse off: never touch the shared line
      FAIL_SYNC_PIN_OE_N_O <= ~(FAIL_SYNC_ENABLE_FUSE_I & drive_low_c); // RL15 RL17
      POWERUP_ENABLE_O <= (state_d == sofs_pkg::FS_ON); // RL19
      POWERDOWN_START_O <= pd_start_d;
      FUSE_RELOAD_O <= reload_d; // RL20
    end
  end

  // programming strap consequences and slave address
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      MIRROR_PROGRAMMING_MODE_O <= 1'b0;
      WDOG_DISABLE_O <= 1'b0;
      CRC_SECURE_DISABLE_O <= 1'b0;
      I2C_ADDR_O <= sofs_pkg::I2C_BASE_ADDR;
    end else begin
      MIRROR_PROGRAMMING_MODE_O <= strap_s; // RL11
      WDOG_DISABLE_O <= strap_s; // RL13
      CRC_SECURE_DISABLE_O <= strap_s & ~POWER_ON_REQUEST_I; // RL14
      I2C_ADDR_O <= addr_c;
    end
  end

  // strap forces the fixed address, else fuse code offsets the base
  assign addr_c = strap_s ? sofs_pkg::I2C_STRAP_ADDR
                          : sofs_pkg::I2C_BASE_ADDR + {4'h0, I2C_ADDR_FUSE_I}; // RL12 RL21

  // byte receiver
  sofs_i2c_rx u_rx (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .scl_i(pins_s[sofs_pkg::PIN_SCL]),
    .sda_i(pins_s[sofs_pkg::PIN_SDA]),
    .addr_i(addr_c),
    .byte_valid_o(rx_valid),
    .byte_o(rx_byte),
    .sda_oe_n_o(rx_oe_n)
  );

  // retimed receiver outputs, one cycle behind the receiver
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      I2C_BYTE_VALID_O <= 1'b0;
      I2C_BYTE_O <= 8'h00;
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
    end else begin
      I2C_BYTE_VALID_O <= rx_valid; // RL22
      I2C_BYTE_O <= rx_byte;
      SDA_O <= 1'b0;
      SDA_OE_N_O <= rx_oe_n;
    end
  end
endmodule

// ===== sim/sofs_props.sv
`timescale 1ns/1ps
// port-level checker, bound onto the top below
module sofs_props #(
  parameter int NUM_REG = 7
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic FAIL_SYNC_ENABLE_FUSE_I,
  input wire logic [2:0] I2C_ADDR_FUSE_I,
  input wire sofs_pkg::sofs_sel_s SAFE_SEL_I,
  input wire logic [NUM_REG-1:0] OVERVOLT_FAULT_I,
  input wire sofs_pkg::sofs_hard_s HARD_FAULT_I,
  input wire logic SUPPLY_UNDERVOLT_DETECT_I,
  input wire logic SAFETY_OUTPUT_OE_N_O,
  input wire sofs_pkg::sofs_flags_s SAFE_FLAGS_O,
  input wire logic FAIL_SYNC_PIN_OE_N_O,
  input wire logic POWERUP_ENABLE_O,
  input wire logic POWERDOWN_START_O,
  input wire logic MIRROR_PROGRAMMING_MODE_O,
  input wire logic WDOG_DISABLE_O,
  input wire logic [6:0] I2C_ADDR_O
);
  default clocking dcb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  strap_modes_a: assert property (WDOG_DISABLE_O == MIRROR_PROGRAMMING_MODE_O)
    else $error("strap outputs disagree");
  strap_addr_a: assert property (MIRROR_PROGRAMMING_MODE_O [*2] |-> I2C_ADDR_O == 7'h08)
    else $error("strap address wrong");
  // two quiet cycles absorb the lag after a fuse change
  addr_map_a: assert property ((!MIRROR_PROGRAMMING_MODE_O && $stable(I2C_ADDR_FUSE_I)) [*2]
    |-> I2C_ADDR_O == {4'h1, I2C_ADDR_FUSE_I}) else $error("address map wrong");
  soft_latch_a: assert property (SAFE_SEL_I.safe_sel_soft_fault && |OVERVOLT_FAULT_I && !SUPPLY_UNDERVOLT_DETECT_I
    |=> SAFE_FLAGS_O.soft_fault_safe_flag && !SAFETY_OUTPUT_OE_N_O) else $error("soft fault missed");
  soft_sel_a: assert property ($rose(SAFE_FLAGS_O.soft_fault_safe_flag) |-> $past(SAFE_SEL_I.safe_sel_soft_fault))
    else $error("soft flag unselected");
  hard_sel_a: assert property ($rose(SAFE_FLAGS_O.hard_fault_safe_flag) |-> $past(SAFE_SEL_I.safe_sel_hard_fault))
    else $error("hard flag unselected");
  uv_release_a: assert property (SUPPLY_UNDERVOLT_DETECT_I |=> SAFETY_OUTPUT_OE_N_O && SAFE_FLAGS_O == 5'h00)
    else $error("undervolt did not release");
  fs_ignore_a: assert property (!FAIL_SYNC_ENABLE_FUSE_I |=> FAIL_SYNC_PIN_OE_N_O)
    else $error("fail-sync driven while off");
  own_fault_a: assert property (FAIL_SYNC_ENABLE_FUSE_I && POWERUP_ENABLE_O && |HARD_FAULT_I
    |=> !FAIL_SYNC_PIN_OE_N_O ##200 !POWERDOWN_START_O ##200 POWERDOWN_START_O) else $error("fail-sync lead wrong");
  cover property (POWERDOWN_START_O);
  cover property ($rose(SAFE_FLAGS_O.hard_fault_safe_flag));
  cover property (MIRROR_PROGRAMMING_MODE_O && I2C_ADDR_O == 7'h08);
endmodule

bind sofs_top sofs_props #(.NUM_REG(NUM_REG)) sofs_props_inst (.*);

// ===== sim/sofs_peer.sv
`timescale 1ns/1ps
// peer chip on the open-drain fail-sync wire
module sofs_peer (
  input wire logic clk_i,
  input wire logic hold_low_i, // peer not ready, or peer failed
  output logic oe_n_o // 0 while pulling low
);
  // peer logic moves only on its clock edge
  always_ff @(posedge clk_i) begin
    oe_n_o <= ~hold_low_i;
  end
endmodule

// ===== sim/safety_output_fail_sync_ctrl_tb.sv
`timescale 1ns/1ps
// fault mode, then reset into active mode, fail-sync off
module safety_output_fail_sync_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, asf = 1'b0, fse = 1'b1, strap = 1'b0, mrn = 1'b1;
  logic wdog_input = 1'b0, swr = 1'b0, wdc = 1'b0, hwd = 1'b0, uv = 1'b0, pon = 1'b0, pdd = 1'b0, hold = 1'b0;
  logic [2:0] af = 3'h0;
  logic [13:0] st = 14'h0000;
  logic [20:0] rf = 21'h000000; // ov, uv, current_limit_fault lanes
  logic [16:0] rnd = 17'h14ED2;
  logic [4:0] mf = 5'h00; // model of the flags
  sofs_pkg::sofs_sel_s sel = 4'h0;
  sofs_pkg::sofs_hard_s hf = 5'h00;
  sofs_pkg::sofs_flags_s clr = 5'h00;
  sofs_pkg::sofs_flags_s flg;
  logic soe, fso, pue, pds, frl, mpm, wdd, crc, peer_n;
  logic [6:0] ia;
  wire fs_pin = fso & peer_n; // pulled up, either side pulls low
  int num_errors = 0, checks_done = 0, n;
  sofs_top sofs_top_inst (.MCLK_I(clk), .RST_I(rst), .ACTIVE_SAFE_MODE_FUSE_I(asf), .FAIL_SYNC_ENABLE_FUSE_I(fse),
    .I2C_ADDR_FUSE_I(af), .SAFE_SEL_I(sel), .MCU_RESET_OUT_N_I(mrn), .ANALOG_SELF_TEST_I(st),
    .OVERVOLT_FAULT_I(rf[6:0]), .UNDERVOLT_FAULT_I(rf[13:7]), .CURRENT_LIMIT_FAULT_I(rf[20:14]),
    .HARD_FAULT_I(hf), .WDOG_INPUT_EVENT_I(wdog_input), .SOFT_WDOG_RESET_I(swr), .WDOG_COUNTER_RESET_I(wdc),
    .HARD_WDOG_EVENT_I(hwd), .SUPPLY_UNDERVOLT_DETECT_I(uv), .FLAG_CLEAR_I(clr), .POWER_ON_REQUEST_I(pon),
    .POWERDOWN_DONE_I(pdd), .CONFIG_MODE_STRAP_I(strap), .FAIL_SYNC_PIN_I(fs_pin), .SCL_I(1'b1), .SDA_I(1'b1),
    .SAFETY_OUTPUT_O(), .SAFETY_OUTPUT_OE_N_O(soe), .SAFE_FLAGS_O(flg), .FAIL_SYNC_PIN_O(),
    .FAIL_SYNC_PIN_OE_N_O(fso), .POWERUP_ENABLE_O(pue), .POWERDOWN_START_O(pds), .FUSE_RELOAD_O(frl),
    .MIRROR_PROGRAMMING_MODE_O(mpm), .WDOG_DISABLE_O(wdd), .CRC_SECURE_DISABLE_O(crc), .I2C_ADDR_O(ia),
    .I2C_BYTE_VALID_O(), .I2C_BYTE_O(), .SDA_O(), .SDA_OE_N_O());
  sofs_peer sofs_peer_inst (.clk_i(clk), .hold_low_i(hold), .oe_n_o(peer_n));
  // 20 MHz
  initial forever #25 clk = ~clk;
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // inputs change 1 ns after an edge, outputs read there too
  task cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask
  // flags and pin follow the model
  task fchk;
    chk("flags", flg, mf);
    chk("safe_oe_n", soe, mf == 5'h00);
  endtask
  // lane k: 0 soft fault, 1 wdog input, 2 soft wdog reset, 3 wdog counter
  task ev(input int k, input logic on);
    sel = {on & (k == 1 || k == 2), on & (k == 3), on & (k == 0), 1'b0};
    rnd = lfsr(rnd);
    rf = (k == 0) ? 21'h000001 << (rnd % 21) : 21'h000000;
    {wdog_input, swr, wdc} = {k == 1, k == 2, k == 3};
    cy(1);
    {rf, wdog_input, swr, wdc} = 24'h000000;
    cy(3);
    // strap mutes every watchdog lane
    if (on && !(strap && k > 0))
      mf[k == 0 ? 3 : k == 3 ? 1 : 2] = 1'b1;
    fchk;
    clr = mf;
    cy(1);
    clr = 5'h00;
    mf = 5'h00;
    fchk;
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, ~4x the run
  initial begin
    #1000000;
    num_errors++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    cy(3);
    fchk;
    for (int k = 0; k < 8; k++)
      ev(k / 2, k % 2);
    sel = 4'h2;
    rf = 21'h000001;
    cy(1);
    {rf, uv} = 22'h000001;
    cy(1);
    uv = 1'b0;
    fchk;
    for (int c = 0; c < 8; c++) begin
      af = c;
      cy(2);
      chk("addr", ia, 8'h08 + c);
    end
    strap = 1'b1;
    cy(4);
    chk("mirror", mpm, 1'b1);
    chk("wdog_off", wdd, 1'b1);
    chk("crc_off", crc, 1'b1);
    chk("strap_addr", ia, 8'h08);
    ev(1, 1'b1);
    ev(3, 1'b1);
    {hold, pon} = 2'h3;
    cy(20);
    chk("crc_on", crc, 1'b0);
    chk("held", pue, 1'b0);
    chk("fs_rel", fso, 1'b1);
    {hold, strap} = 2'h0;
    cy(8);
    chk("powerup", pue, 1'b1);
    // each hard cause, last one unselected
    for (int k = 0; k < 6; k++) begin
      sel = {3'h0, k < 5};
      hf = 5'h01 << (k % 5);
      cy(1);
      hf = 5'h00;
      mf[0] = (k < 5);
      fchk;
      chk("fs_drive", fso, 1'b0);
      cy(399);
      chk("pd_early", pds, 1'b0);
      cy(1);
      chk("pd_start", pds, 1'b1);
      {pon, pdd, clr} = {2'h1, mf};
      cy(1);
      {pdd, clr} = 6'h00;
      mf = 5'h00;
      cy(3);
      chk("off_low", fso, 1'b0);
      pon = 1'b1;
      cy(8);
      chk("powerup", pue, 1'b1);
    end
    hold = 1'b1;
    cy(398);
    chk("peer_debounce", fso, 1'b1);
    cy(10);
    chk("peer_fail", fso, 1'b0);
    {hold, pdd} = 2'h1;
    cy(1);
    pdd = 1'b0;
    cy(8);
    chk("powerup", pue, 1'b1);
    hwd = 1'b1;
    cy(1);
    hwd = 1'b0;
    chk("hwd_drive", fso, 1'b0);
    cy(402);
    pdd = 1'b1;
    cy(1);
    pdd = 1'b0;
    n = 0;
    while (frl !== 1'b1 && n < 700) begin
      cy(1);
      n++;
    end
    chk("reload_wait", n > 596 && n < 604, 1'b1);
    cy(8);
    chk("fs_release", fso, 1'b1);
    chk("restart", pue, 1'b1);
    // reset again: active mode, fuse off, peer low
    {rst, fse, asf, hold} = 4'hB;
    cy(3);
    rst = 1'b0;
    cy(2);
    mf = 5'h10;
    fchk;
    cy(450);
    chk("fs_ignored", fso, 1'b1);
    chk("fs_no_pause", pue, 1'b1);
    for (int k = 0; k < 4; k++) begin
      st = (k == 0) ? 14'h0001 << (rnd % 14) : 14'h0000;
      mrn = (k != 1);
      rf = (k == 2) ? 21'h000001 : 21'h000000;
      cy(2);
      clr = 5'h10;
      cy(1);
      clr = 5'h00;
      mf = (k == 3) ? 5'h00 : 5'h10;
      fchk;
    end
    wrap_up;
  end
endmodule
